// [rtl/crc_pkg.sv]
// package: register map, field positions and reset values of the comparator/reference control
package crc_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] OFF_CMP_CTRL1   = 8'h00;
  localparam logic [7:0] OFF_CMP_CTRL2   = 8'h04;
  localparam logic [7:0] OFF_CMP_CTRL3   = 8'h08;
  localparam logic [7:0] OFF_MOD_STATUS  = 8'h0c;
  localparam logic [7:0] OFF_REF_CTRL    = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h18;

  // comparator_control fields
  localparam int CC_ENABLE      = 15;
  localparam int CC_PIN_OE      = 14;
  localparam int CC_INVERT      = 13;
  localparam int CC_EVENT       = 9;
  localparam int CC_OUTPUT      = 8;
  localparam int CC_EDGE_HI     = 7;
  localparam int CC_EDGE_LO     = 6;
  localparam int CC_NONINV_REF  = 4;
  localparam int CC_INV_SEL_HI  = 1;
  localparam int CC_INV_SEL_LO  = 0;
  // writable bits of comparator_control (event flag handled apart)
  localparam logic [15:0] CC_WMASK = 16'he0d3;

  // comparator_module_status fields
  localparam int MS_IDLE_STOP   = 15;
  localparam int MS_EVENT_LO    = 8;
  localparam int MS_OUTPUT_LO   = 0;

  // voltage_reference_control fields
  localparam int RC_POWER       = 7;
  localparam int RC_PIN_OE      = 6;
  localparam int RC_RANGE       = 5;
  localparam int RC_SOURCE      = 4;
  localparam logic [15:0] RC_WMASK = 16'h00ff;

  // reset values
  localparam logic [15:0] CC_RESET   = 16'h0000;
  localparam logic [15:0] RC_RESET   = 16'h0000;
  localparam logic        IDLE_RESET = 1'b0;
  localparam logic [2:0]  IRQ_RESET  = 3'h0;

  // inverting input codes
  localparam logic [1:0] INV_PIN_B   = 2'h0;
  localparam logic [1:0] INV_PIN_C   = 2'h1;
  localparam logic [1:0] INV_PIN_D   = 2'h2;
  localparam logic [1:0] INV_HALF_BG = 2'h3;

  // event edge codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY  = 2'h3;

  typedef enum logic [1:0] {
    APB_IDLE   = 2'b00,
    APB_ACCESS = 2'b01
  } crc_apb_st_t;
endpackage

// [rtl/crc_sync_if.sv]
// interface: raw comparator outputs in, synchronised levels out
`timescale 1ns/1ns
interface crc_sync_if;
  logic [2:0] raw;
  logic [2:0] sync;
  modport src (output raw, input sync);
  modport snk (input raw, output sync);
endinterface

// [rtl/crc_sync.sv]
// two-flop synchroniser for the three comparator outputs
`timescale 1ns/1ns
module crc_sync (
  input  wire logic clk,     // system clock
  input  wire logic arst_n,  // async reset, active low
  crc_sync_if.snk   sif      // raw in, synced out
);
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
  } crc_sync_st_t;

  crc_sync_st_t s_q;
  crc_sync_st_t s_d;

  always_comb begin
    s_d.meta = sif.raw;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.sync = s_q.sync;
endmodule

// [rtl/crc_top.sv]
// top: comparator control, module status and voltage reference control over APB
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
module crc_top (
  input  wire logic        clk,             // system clock, 20 MHz
  input  wire logic        arst_n,          // async reset, active low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb enable
  input  wire logic        pwrite,          // apb direction
  input  wire logic [7:0]  paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error, unmapped address
  input  wire logic        sys_idle,        // system in idle mode
  input  wire logic [2:0]  cmp_raw,         // analog comparator outputs, async
  output logic      [2:0]  cmp_enable,      // comparator power enable
  output logic      [2:0]  cmp_pin_oe,      // comparator output to pad
  output logic      [2:0]  noninv_ref_select, // 1 = programmable reference
  output logic      [5:0]  inv_input_select,  // 2 bits per comparator
  output logic      [2:0]  cmp_out,         // polarity-applied outputs
  output logic             ref_power_enable,      // reference powered
  output logic             ref_pin_output_enable, // reference to pin
  output logic             ref_range_select,      // 1 low range
  output logic             ref_source_select,     // 1 external pins
  output logic      [3:0]  ref_level_code,        // level code
  output logic             irq              // level interrupt
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    crc_pkg::crc_apb_st_t apb;
    logic [31:0]          rdata;
    logic                 ready;
    logic                 err;
    logic [2:0][15:0]     cc;      // comparator_control, event/output bits kept apart
    logic [2:0]           evt;
    logic [2:0]           outp;    // polarity-applied, registered
    logic                 idle_stop;
    logic [7:0]           rc;
    logic [2:0]           irq_st;
    logic [2:0]           irq_mask;
    logic                 irq;
  } crc_st_t;

  crc_st_t s_q;
  crc_st_t s_d;

  crc_sync_if sif ();
  assign sif.raw = cmp_raw;

  crc_sync u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .sif    (sif)
  );

  // ------------------------------------------------------------
  // per-comparator output and event detection
  // ------------------------------------------------------------
  logic [2:0] out_now;
  logic [2:0] hit;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cmp
      logic       rise;
      logic       fall;
      logic [1:0] esel;
      assign out_now[gi] = sif.sync[gi] ^ s_q.cc[gi][crc_pkg::CC_INVERT];
      assign rise = out_now[gi] & ~s_q.outp[gi];
      assign fall = ~out_now[gi] & s_q.outp[gi];
      assign esel = s_q.cc[gi][crc_pkg::CC_EDGE_HI:crc_pkg::CC_EDGE_LO];
      // edges judged on the inverted output, so codes 01/10 swap with polarity
      always_comb begin
        case (esel)
          crc_pkg::EDGE_OFF:  hit[gi] = 1'b0;
          crc_pkg::EDGE_RISE: hit[gi] = rise;
          crc_pkg::EDGE_FALL: hit[gi] = fall;
          crc_pkg::EDGE_ANY:  hit[gi] = rise | fall;
          default:            hit[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  function automatic logic [15:0] cc_view(input logic [15:0] c, input logic e,
                                          input logic o);
    logic [15:0] v;
    v = c & crc_pkg::CC_WMASK;
    v[crc_pkg::CC_EVENT]  = e;
    v[crc_pkg::CC_OUTPUT] = o;
    return v;
  endfunction

  logic [31:0] rd_val;
  logic        hit_addr;

  always_comb begin
    rd_val   = 32'h0000_0000;
    hit_addr = 1'b1;
    case (paddr)
      crc_pkg::OFF_CMP_CTRL1: rd_val[15:0] = cc_view(s_q.cc[0], s_q.evt[0], s_q.outp[0]);
      crc_pkg::OFF_CMP_CTRL2: rd_val[15:0] = cc_view(s_q.cc[1], s_q.evt[1], s_q.outp[1]);
      crc_pkg::OFF_CMP_CTRL3: rd_val[15:0] = cc_view(s_q.cc[2], s_q.evt[2], s_q.outp[2]);
      crc_pkg::OFF_MOD_STATUS: begin
        rd_val[crc_pkg::MS_IDLE_STOP] = s_q.idle_stop;
        rd_val[crc_pkg::MS_EVENT_LO +: 3] = s_q.evt;
        rd_val[crc_pkg::MS_OUTPUT_LO +: 3] = s_q.outp;
      end
      crc_pkg::OFF_REF_CTRL:   rd_val[7:0] = s_q.rc;
      crc_pkg::OFF_IRQ_STATUS: rd_val[2:0] = s_q.irq_st;
      crc_pkg::OFF_IRQ_MASK:   rd_val[2:0] = s_q.irq_mask;
      default:                 hit_addr    = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic wr_now;
  logic idle_block;

  always_comb begin
    s_d        = s_q;
    wr_now     = 1'b0;
    idle_block = s_q.idle_stop & sys_idle;
    s_d.ready  = 1'b0;
    s_d.err    = 1'b0;

    // one wait state: setup, access (ready low), access (ready high)
    case (s_q.apb)
      crc_pkg::APB_IDLE: begin
        if (psel && penable) begin
          s_d.apb   = crc_pkg::APB_ACCESS;
          s_d.ready = 1'b1;
          s_d.err   = ~hit_addr;
          s_d.rdata = pwrite ? 32'h0000_0000 : rd_val;
          wr_now    = pwrite & hit_addr;
        end
      end
      crc_pkg::APB_ACCESS: begin
        s_d.apb = crc_pkg::APB_IDLE;
      end
      default: s_d.apb = crc_pkg::APB_IDLE;
    endcase

    s_d.outp = out_now;

    // software writes; unimplemented bits masked off
    if (wr_now) begin
      case (paddr)
        crc_pkg::OFF_CMP_CTRL1: s_d.cc[0] = pwdata[15:0] & crc_pkg::CC_WMASK;
        crc_pkg::OFF_CMP_CTRL2: s_d.cc[1] = pwdata[15:0] & crc_pkg::CC_WMASK;
        crc_pkg::OFF_CMP_CTRL3: s_d.cc[2] = pwdata[15:0] & crc_pkg::CC_WMASK;
        crc_pkg::OFF_MOD_STATUS: s_d.idle_stop = pwdata[crc_pkg::MS_IDLE_STOP];
        crc_pkg::OFF_REF_CTRL:   s_d.rc = pwdata[7:0];
        crc_pkg::OFF_IRQ_STATUS: s_d.irq_st = s_q.irq_st & ~pwdata[2:0];
        crc_pkg::OFF_IRQ_MASK:   s_d.irq_mask = pwdata[2:0];
        default: ;
      endcase
      // event flag is software clearable via its control register
      if (paddr == crc_pkg::OFF_CMP_CTRL1) s_d.evt[0] = pwdata[crc_pkg::CC_EVENT];
      if (paddr == crc_pkg::OFF_CMP_CTRL2) s_d.evt[1] = pwdata[crc_pkg::CC_EVENT];
      if (paddr == crc_pkg::OFF_CMP_CTRL3) s_d.evt[2] = pwdata[crc_pkg::CC_EVENT];
    end

    // a flagged comparator raises no further events, even in the cycle its flag is cleared; a set beats a same-cycle irq status clear
    for (int i = 0; i < 3; i++) begin
      if (hit[i] && !s_q.evt[i]) begin
        s_d.evt[i] = 1'b1;
        if (!idle_block) begin
          s_d.irq_st[i] = 1'b1;
        end
      end
    end

    s_d.irq = |(s_d.irq_st & s_d.irq_mask);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q           <= '0;
      s_q.apb       <= crc_pkg::APB_IDLE;
      s_q.idle_stop <= crc_pkg::IDLE_RESET;
      s_q.rc        <= crc_pkg::RC_RESET[7:0];
      s_q.irq_st    <= crc_pkg::IRQ_RESET;
      s_q.irq_mask  <= crc_pkg::IRQ_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flops
  // ------------------------------------------------------------
  generate
    for (gi = 0; gi < 3; gi++) begin : g_out
      assign cmp_enable[gi]        = s_q.cc[gi][crc_pkg::CC_ENABLE];
      assign cmp_pin_oe[gi]        = s_q.cc[gi][crc_pkg::CC_PIN_OE];
      assign noninv_ref_select[gi] = s_q.cc[gi][crc_pkg::CC_NONINV_REF];
      assign inv_input_select[2*gi +: 2] =
        s_q.cc[gi][crc_pkg::CC_INV_SEL_HI:crc_pkg::CC_INV_SEL_LO];
    end
  endgenerate

  assign cmp_out               = s_q.outp;
  assign ref_power_enable      = s_q.rc[crc_pkg::RC_POWER];
  assign ref_pin_output_enable = s_q.rc[crc_pkg::RC_PIN_OE];
  assign ref_range_select      = s_q.rc[crc_pkg::RC_RANGE];
  assign ref_source_select     = s_q.rc[crc_pkg::RC_SOURCE];
  // ladder maps code to code/24 or 1/4 + code/32 of the span per range
  assign ref_level_code        = s_q.rc[3:0];
  assign prdata                = s_q.rdata;
  assign pready                = s_q.ready;
  assign pslverr               = s_q.err;
  assign irq                   = s_q.irq;
endmodule

// [test/crc_monitor.sv]
// checker: bus timing, register effects and comparator path of crc_top
`timescale 1ns/1ns
module crc_monitor (
  input wire logic        clk,                   // clock
  input wire logic        arst_n,                // reset
  input wire logic        psel,                  // apb
  input wire logic        penable,               // apb
  input wire logic        pwrite,                // apb
  input wire logic [7:0]  paddr,                 // apb
  input wire logic [31:0] pwdata,                // apb
  input wire logic [31:0] prdata,                // apb
  input wire logic        pready,                // apb
  input wire logic        pslverr,               // apb
  input wire logic [2:0]  cmp_raw,               // analog
  input wire logic [2:0]  cmp_enable,            // control
  input wire logic [2:0]  noninv_ref_select,     // control
  input wire logic [5:0]  inv_input_select,      // control
  input wire logic [2:0]  cmp_out,               // synced
  input wire logic        ref_power_enable,      // ref
  input wire logic        ref_pin_output_enable, // ref
  input wire logic        ref_range_select,      // ref
  input wire logic        ref_source_select,     // ref
  input wire logic [3:0]  ref_level_code,        // ref
  input wire logic        irq                    // interrupt
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [31:0] wd_q;
  logic [2:0]  out_q;
  wire         rd_done = pready && !pwrite;
  wire         wr_take = psel && penable && pwrite && !pready;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_q  <= 32'h0;
      out_q <= 3'h0;
    end else begin
      wd_q  <= pwdata;
      out_q <= cmp_out;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_ONE_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("access phase not two cycles");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  AST_UNMAPPED: assert property (rd_done && paddr == 8'h1c |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  AST_STATUS_READ: assert property (rd_done && paddr == crc_pkg::OFF_MOD_STATUS
    |-> prdata[14:11] == 4'h0 && prdata[7:3] == 5'h0 && prdata[2:0] == out_q)
    else $error("status read wrong");
  AST_CTRL_READ: assert property (rd_done && paddr == crc_pkg::OFF_CMP_CTRL1
    |-> prdata[8] == out_q[0] && prdata[12:10] == 3'h0 && prdata[5] == 1'b0
    && prdata[3:2] == 2'h0) else $error("control read wrong");
  AST_REF_WRITE: assert property (wr_take && paddr == crc_pkg::OFF_REF_CTRL |=>
    {ref_power_enable, ref_pin_output_enable, ref_range_select, ref_source_select,
    ref_level_code} == wd_q[7:0]) else $error("reference outputs wrong");
  AST_CTRL_WRITE: assert property (wr_take && paddr == crc_pkg::OFF_CMP_CTRL1 |=>
    cmp_enable[0] == wd_q[15] && noninv_ref_select[0] == wd_q[4]
    && inv_input_select[1:0] == wd_q[1:0]) else $error("control outputs wrong");
  AST_SYNC_DELAY: assert property (($changed(cmp_raw) && !psel)
    ##1 (!psel && $stable(cmp_raw))[*3]
    |-> cmp_out != $past(cmp_out) && $past(cmp_out) == $past(cmp_out, 2))
    else $error("output not three edges after input");
  // irq registers from the next status, so it rises on the edge that moves cmp_out
  AST_IRQ_CAUSE: assert property ($rose(irq)
    |-> cmp_out != $past(cmp_out) || $past(psel))
    else $error("interrupt without event");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
bind crc_top crc_monitor crc_monitor_i (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
  .noninv_ref_select(noninv_ref_select), .inv_input_select(inv_input_select),
  .cmp_out(cmp_out), .ref_power_enable(ref_power_enable),
  .ref_pin_output_enable(ref_pin_output_enable), .ref_range_select(ref_range_select),
  .ref_source_select(ref_source_select), .ref_level_code(ref_level_code), .irq(irq));

// [test/crc_cmp_model.sv]
// behavioural model of the three analog comparators feeding crc_top
`timescale 1ns/1ns
module crc_cmp_model #(
  parameter int RESP_NS = 7 // response time, raise for a slow part
) (
  input  wire logic [2:0] vin_gt,     // 1 where + input exceeds - input
  input  wire logic [2:0] cmp_enable, // comparator powered
  output logic      [2:0] cmp_raw     // async outputs
);
  // a powered-down comparator holds its output low
  initial cmp_raw = 3'h0;
  always @(vin_gt or cmp_enable) cmp_raw <= #RESP_NS vin_gt & cmp_enable;
endmodule

// [test/crc_top_tb_top.sv]
// testbench: registers, reference control, events and idle gating of crc_top
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  n_tests++; \
  if ((got) !== (ex)) begin \
    failures++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); \
  end
module crc_top_tb_top;
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, irq, sys_idle = 1'b0;
  logic [2:0]  vin = 3'h0, cmp_raw, cmp_enable, noninv, cmp_out, pin_oe;
  logic [5:0]  inv_sel;
  logic [7:0]  ref_o;
  int          failures = 0, n_tests = 0;
  always #25 clk = ~clk;
  crc_top crc_top_i (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_idle(sys_idle), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
    .cmp_pin_oe(pin_oe), .noninv_ref_select(noninv), .inv_input_select(inv_sel),
    .cmp_out(cmp_out), .ref_power_enable(ref_o[7]), .ref_pin_output_enable(ref_o[6]),
    .ref_range_select(ref_o[5]), .ref_source_select(ref_o[4]),
    .ref_level_code(ref_o[3:0]), .irq(irq));
  crc_cmp_model crc_cmp_model_i (.vin_gt(vin), .cmp_enable(cmp_enable), .cmp_raw(cmp_raw));
  // ----------------------------------------
  // bus and wait helpers
  // ----------------------------------------
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin failures++; summarize(); end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wait_irq;
    int i;
    for (i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
    `CHK("irq raised", 1'b1, irq)
    if (irq !== 1'b1) summarize();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped error", 1'b1, err)
  endtask
  task t_ref;
    for (int k = 0; k < 16; k++) begin
      apb(1'b1, crc_pkg::OFF_REF_CTRL, 32'hffff_ff00 | 32'(k * 17));
      `CHK("ref outputs", 8'(k * 17), ref_o)
    end
    // give the ladder time to settle before anything leans on it
    repeat (4) @(posedge clk);
    apb(1'b0, crc_pkg::OFF_REF_CTRL, 32'h0);
    `CHK("ref readback", 32'h0000_00ff, rd)
  endtask
  task t_ctrl;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, crc_pkg::OFF_CMP_CTRL3, 32'hffff_fd3c | 32'(k));
      apb(1'b0, crc_pkg::OFF_CMP_CTRL3, 32'h0);
      `CHK("ctrl readback", 32'h0000_e110 | 32'(k), rd)
      `CHK("inv select", 2'(k), inv_sel[5:4])
      `CHK("ref select", 1'b1, noninv[2])
      `CHK("enable and pad", 2'b11, {cmp_enable[2], pin_oe[2]})
    end
    apb(1'b1, crc_pkg::OFF_CMP_CTRL3, 32'h0);
    `CHK("pin a select", 1'b0, noninv[2])
    `CHK("pad off", 3'h0, pin_oe)
  endtask
  task t_event;
    apb(1'b1, crc_pkg::OFF_IRQ_MASK, 32'h1);
    apb(1'b1, crc_pkg::OFF_CMP_CTRL1, 32'h0000_8040);
    @(posedge clk) vin <= 3'b001;
    wait_irq();
    apb(1'b0, crc_pkg::OFF_MOD_STATUS, 32'h0);
    `CHK("status copies", 32'h0000_0101, rd)
    // clear the interrupt first so a leaked second event would show on irq
    apb(1'b1, crc_pkg::OFF_IRQ_STATUS, 32'h1);
    @(posedge clk) vin <= 3'b000;
    repeat (6) @(posedge clk);
    vin <= 3'b001;
    repeat (6) @(posedge clk);
    `CHK("blocked event", 1'b0, irq)
    apb(1'b1, crc_pkg::OFF_CMP_CTRL1, 32'h0000_8040);
    apb(1'b0, crc_pkg::OFF_CMP_CTRL1, 32'h0);
    `CHK("flag cleared", 32'h0000_8140, rd)
    apb(1'b1, crc_pkg::OFF_CMP_CTRL1, 32'h0);
  endtask
  task t_idle;
    apb(1'b1, crc_pkg::OFF_MOD_STATUS, 32'h8000);
    sys_idle <= 1'b1;
    apb(1'b1, crc_pkg::OFF_IRQ_MASK, 32'h2);
    apb(1'b1, crc_pkg::OFF_CMP_CTRL2, 32'h0000_80c0);
    @(posedge clk) vin <= 3'b010;
    repeat (8) @(posedge clk);
    `CHK("idle gated irq", 1'b0, irq)
    apb(1'b0, crc_pkg::OFF_MOD_STATUS, 32'h0);
    `CHK("idle status", 32'h0000_8202, rd)
    apb(1'b1, crc_pkg::OFF_MOD_STATUS, 32'h0);
    apb(1'b1, crc_pkg::OFF_CMP_CTRL2, 32'h0000_80c0);
    @(posedge clk) vin <= 3'b000;
    wait_irq();
  endtask
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_ref();
    t_ctrl();
    t_event();
    t_idle();
    summarize();
  end
endmodule
